// ===== core/gdio_pkg.sv
/*
 * Shared constants for the general digital I/O port block: port count,
 * widths, I/O-space addresses, field positions and reset values.
 * Assumes an 8-bit I/O space with a 6-bit address.
 */
`default_nettype none
package gdio_pkg;
	localparam int NUM_PORTS = 3;
	localparam int PORT_W = 8;
	localparam int ADDR_W = 6;
	localparam int IDX_W = 3;
	localparam int PINS_W = NUM_PORTS * PORT_W;

	// each port owns three consecutive locations
	localparam logic [5:0] PORT_BASE = 6'h03;
	localparam logic [5:0] PORT_STRIDE = 6'h03;
	localparam logic [5:0] SAMPLE_OFS = 6'h00;
	localparam logic [5:0] DIR_OFS = 6'h01;
	localparam logic [5:0] OUT_OFS = 6'h02;
	localparam logic [5:0] MCU_CTRL_ADDR = 6'h35;

	localparam logic [7:0] MCU_CTRL_RST = 8'h00;
	localparam logic [7:0] MCU_CTRL_RW_MASK = 8'h93;
	localparam int PULLUP_OFF_BIT = 4;
	localparam logic [7:0] DIR_RST = 8'h00;
	localparam logic [7:0] OUT_RST = 8'h00;
	localparam logic [7:0] SAMPLE_RST = 8'h00;
	localparam logic [7:0] RDATA_RST = 8'h00;

	typedef logic [ADDR_W-1:0] gdio_addr_t;

	function automatic gdio_addr_t gdio_reg_addr(input int port, input logic [5:0] ofs);
		logic [5:0] p;
		p = 6'(port);
		return 6'(PORT_BASE + PORT_STRIDE * p + ofs);
	endfunction
endpackage
`default_nettype wire

// ===== core/gdio_port.sv
/*
 * General digital I/O ports: per-pin direction, output value / pull-up
 * and synchronized pin sample, plus the shared control register.
 * Assumes a simple I/O-space access port and pads that resolve
 * drive, enable and pull-up outside this module.
 */
// Notes on behaviour
// - a direction bit of one makes the pin an output, zero makes it an input.
// - an input pin whose value bit is one has its pull-up on, otherwise it is off.
// - reset tri-states every pin at once without needing a clock.
// - an output pin drives high for value bit one and low for zero.
// - writing one to a pin-sample bit inverts the matching value bit; zero does nothing.
// - the global pull-up-off bit at control bit 4 removes every pull-up.
// - with the global disable set an input with value one stays high-impedance; outputs ignore it.
// - each port has a read/write value register, a read/write direction register and a pin-sample register.
// - single-bit set or clear touches only the addressed bit.
// - the pin-sample register follows the pad in either direction through two stages.
// - the first stage is a latch open while the clock is high, loaded into the register at the next rise.
// - a value the port drives itself is readable one clock after the write, so software waits a cycle.
// - moving between tri-state and output high passes one intermediate state set by write order.
// - each pin is independent, so another pin's use never changes a pin's behaviour.
// - in deep sleep each digital input is clamped low before the synchronizer unless used for an interrupt.
`timescale 1ns/10ps
`default_nettype none
module gdio_port (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// I/O-space access
	input wire logic [gdio_pkg::ADDR_W-1:0] io_addr,
	input wire logic io_wr,
	input wire logic [7:0] io_wdata,
	input wire logic io_rd,
	output logic [7:0] io_rdata,
	// single-bit set and clear
	input wire logic bit_set_instr,
	input wire logic bit_clear_instr,
	input wire logic [gdio_pkg::IDX_W-1:0] io_bit_idx,
	// sleep controller
	input wire logic sleep_deep,
	input wire logic [gdio_pkg::PINS_W-1:0] ext_int_en,
	// pads
	input wire logic [gdio_pkg::PINS_W-1:0] pad_in,
	output logic [gdio_pkg::PINS_W-1:0] pad_out,
	output logic [gdio_pkg::PINS_W-1:0] pad_oe,
	output logic [gdio_pkg::PINS_W-1:0] pad_pullup,
	// control register view
	output logic global_pullup_off
);
	logic [7:0] mcu_control_ff;
	logic [7:0] nxt_mcu_control;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	logic [gdio_pkg::PINS_W-1:0] direction_reg_ff;
	logic [gdio_pkg::PINS_W-1:0] out_value_reg_ff;
	logic [gdio_pkg::PINS_W-1:0] pin_sample_reg;
	logic [gdio_pkg::PINS_W-1:0] clamped_in;
	logic [7:0] port_rd [gdio_pkg::NUM_PORTS];
	logic [gdio_pkg::NUM_PORTS-1:0] port_hit;
	wire logic [7:0] bit_mask = 8'h01 << io_bit_idx;
	wire logic ctrl_sel = (io_addr == gdio_pkg::MCU_CTRL_ADDR);
	wire logic ctrl_wr = io_wr && ctrl_sel;

	assign global_pullup_off = mcu_control_ff[gdio_pkg::PULLUP_OFF_BIT];
	assign io_rdata = rdata_ff;

	// reserved control bits never store, so they read as zero
	assign nxt_mcu_control = ctrl_wr ? (io_wdata & gdio_pkg::MCU_CTRL_RW_MASK) : mcu_control_ff;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			mcu_control_ff <= gdio_pkg::MCU_CTRL_RST;
		end else begin
			mcu_control_ff <= nxt_mcu_control;
		end
	end

	// deep sleep grounds the input ahead of the latch, saving floating-pad current
	assign clamped_in = pad_in & ~({gdio_pkg::PINS_W{sleep_deep}} & ~ext_int_en);

	gdio_sync u_sync (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.raw_in(clamped_in),
		.sync_ff(pin_sample_reg)
	);

	for (genvar k = 0; k < gdio_pkg::NUM_PORTS; k++) begin : g_port
		localparam int LO = k * gdio_pkg::PORT_W;
		wire logic sel_sample = (io_addr == gdio_pkg::gdio_reg_addr(k, gdio_pkg::SAMPLE_OFS));
		wire logic sel_dir = (io_addr == gdio_pkg::gdio_reg_addr(k, gdio_pkg::DIR_OFS));
		wire logic sel_out = (io_addr == gdio_pkg::gdio_reg_addr(k, gdio_pkg::OUT_OFS));
		wire logic [7:0] dir_q = direction_reg_ff[LO +: 8];
		wire logic [7:0] out_q = out_value_reg_ff[LO +: 8];
		logic [7:0] nxt_dir;
		logic [7:0] nxt_out;

		// bit ops rewrite one bit only, leaving neighbours alone
		assign nxt_dir = (io_wr && sel_dir) ? io_wdata :
			(bit_set_instr && sel_dir) ? (dir_q | bit_mask) :
			(bit_clear_instr && sel_dir) ? (dir_q & ~bit_mask) : dir_q;

		assign nxt_out = (io_wr && sel_out) ? io_wdata :
			(bit_set_instr && sel_out) ? (out_q | bit_mask) :
			(bit_clear_instr && sel_out) ? (out_q & ~bit_mask) :
			(io_wr && sel_sample) ? (out_q ^ io_wdata) :
			(bit_set_instr && sel_sample) ? (out_q ^ bit_mask) : out_q;

		always_ff @(posedge ref_clk or negedge nrst) begin
			if (!nrst) begin
				direction_reg_ff[LO +: 8] <= gdio_pkg::DIR_RST;
				out_value_reg_ff[LO +: 8] <= gdio_pkg::OUT_RST;
			end else begin
				direction_reg_ff[LO +: 8] <= nxt_dir;
				out_value_reg_ff[LO +: 8] <= nxt_out;
			end
		end

		// per-pin drive and pull-up, no cross-pin terms
		assign pad_oe[LO +: 8] = dir_q;
		assign pad_out[LO +: 8] = out_q & dir_q;
		assign pad_pullup[LO +: 8] = ~dir_q & out_q & {8{~global_pullup_off}};

		assign port_hit[k] = sel_sample || sel_dir || sel_out;
		assign port_rd[k] = sel_sample ? pin_sample_reg[LO +: 8] :
			sel_dir ? dir_q :
			sel_out ? out_q : 8'h00;
	end

	always_comb begin
		nxt_rdata = 8'h00;
		if (ctrl_sel) begin
			nxt_rdata = mcu_control_ff;
		end else begin
			for (int k = 0; k < gdio_pkg::NUM_PORTS; k++) begin
				nxt_rdata = nxt_rdata | port_rd[k];
			end
		end
	end

	// unmapped reads answer zero; data held until the next read
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rdata_ff <= gdio_pkg::RDATA_RST;
		end else if (io_rd) begin
			rdata_ff <= nxt_rdata;
		end
	end
endmodule // gdio_port
`default_nettype wire

// ===== core/gdio_sync.sv
/*
 * Pin-input synchronizer: a level latch open while the clock is high,
 * followed by a rising-edge register.
 * Assumes the inputs are raw pad levels, already clamped where needed.
 */
`timescale 1ns/10ps
`default_nettype none
module gdio_sync (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// raw levels and synchronized result
	input wire logic [gdio_pkg::PINS_W-1:0] raw_in,
	output logic [gdio_pkg::PINS_W-1:0] sync_ff
);
	logic [gdio_pkg::PINS_W-1:0] hold_lat;

	// transparent high, holds low; only the register below reads it
	always_latch begin
		if (ref_clk) begin
			hold_lat <= raw_in;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sync_ff <= {gdio_pkg::NUM_PORTS{gdio_pkg::SAMPLE_RST}};
		end else begin
			sync_ff <= hold_lat;
		end
	end
endmodule // gdio_sync
`default_nettype wire

// ===== tb/gdio_pads.sv
/* Board model on the port pads. Assumes bench sets which pins the board drives. */
`timescale 1ns/10ps
`default_nettype none
module gdio_pads (
	// clock and board drive
	input wire logic ref_clk,
	input wire logic [23:0] ext_en, ext_val,
	// port side
	input wire logic [23:0] pad_out, pad_oe, pad_pullup,
	output logic [23:0] pad_in
);
	// floating lines flip each cycle so a stale level never passes
	logic [23:0] float_ff = 24'h5A5A5A;
	always @(posedge ref_clk) begin
		float_ff <= ~float_ff;
	end
	assign pad_in = pad_oe & pad_out | ~pad_oe & (ext_en & ext_val | ~ext_en & (pad_pullup | float_ff));
endmodule // gdio_pads
`default_nettype wire

// ===== tb/gdio_port_assertions.sv
/* Port checker: bus writes against pad outputs. Assumes bind into gdio_port. */
`timescale 1ns/10ps
`default_nettype none
module gdio_port_assertions (
	// clock, reset, bus
	input wire logic ref_clk, nrst, io_wr, io_rd, bit_set_instr, sleep_deep, global_pullup_off,
	input wire logic [5:0] io_addr,
	input wire logic [7:0] io_wdata, io_rdata,
	input wire logic [2:0] io_bit_idx,
	// pads
	input wire logic [23:0] ext_int_en, pad_out, pad_oe, pad_pullup
);
	// port 0 value bits: driven ones plus pulled-up ones, valid while pull-ups are on
	wire logic [7:0] out0 = pad_out[7:0] | pad_pullup[7:0];
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	sequence s_clamp; (sleep_deep && !ext_int_en[7])[*2]; endsequence
	property p_rst; !$past(nrst) |-> !(pad_oe | pad_pullup); endproperty
	property p_dir; io_wr && io_addr == 6'h04 |=> pad_oe[7:0] == $past(io_wdata); endproperty
	property p_drv; io_wr && io_addr == 6'h05 |=> pad_out[7:0] == ($past(io_wdata) & pad_oe[7:0]);
	endproperty
	property p_pu; !(pad_pullup & (pad_oe | {24{global_pullup_off}})); endproperty
	property p_tog; io_wr && io_addr == 6'h03 && !global_pullup_off |=> out0 == ($past(out0) ^ $past(io_wdata));
	endproperty
	property p_set; bit_set_instr && !io_wr && io_addr == 6'h04 |=>
		pad_oe[7:0] == ($past(pad_oe[7:0]) | 8'h01 << $past(io_bit_idx)); endproperty
	property p_gpo; io_wr && io_addr == 6'h35 |=> global_pullup_off == $past(io_wdata[4]); endproperty
	property p_clamp; s_clamp ##0 (io_rd && io_addr == 6'h03) |=> !io_rdata[7]; endproperty
	a_rst: assert property (p_rst) else $error("pads active after reset");
	a_dir: assert property (p_dir) else $error("direction write");
	a_drv: assert property (p_drv) else $error("drive value");
	a_pu: assert property (p_pu) else $error("pull-up on");
	a_tog: assert property (p_tog) else $error("toggle");
	a_set: assert property (p_set) else $error("bit set");
	a_gpo: assert property (p_gpo) else $error("control bit");
	a_clamp: assert property (p_clamp) else $error("sleep clamp");
endmodule // gdio_port_assertions
bind gdio_port gdio_port_assertions chk_u (.*);
`default_nettype wire

// ===== tb/tb_gdio_port.sv
/* Bench: random port setups, toggles, bit ops, control, sleep, reset. Assumes gdio_pads. */
`timescale 1ns/10ps
`default_nettype none
module tb_gdio_port;
	logic ref_clk = 1'h0, nrst = 1'h0, io_wr = 1'h0, io_rd = 1'h0, sleep_deep = 1'h0;
	logic bit_set_instr = 1'h0, bit_clear_instr = 1'h0, global_pullup_off;
	logic [5:0] io_addr = 6'h00;
	logic [2:0] io_bit_idx = 3'h0;
	logic [7:0] io_wdata = 8'h00, io_rdata, d, o, v;
	logic [23:0] ext_int_en = 24'h0, ext_en = 24'hFFFFFF, ext_val = 24'h0;
	logic [23:0] pad_in, pad_out, pad_oe, pad_pullup;
	int n_mismatch = 0, n_checks = 0;
	always #5 ref_clk = ~ref_clk;
	gdio_port dut_u (.*);
	gdio_pads pads_u (.*);
	task automatic chk(input logic [7:0] g, e);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %0t %h %h", $time, g, e);
		end
	endtask
	// k: 0 write, 1 read, 2 bit set, 3 bit clear (index from w)
	task automatic acc(input logic [5:0] a, input logic [7:0] w, input int k);
		@(posedge ref_clk);
		io_addr <= a;
		io_wdata <= w;
		io_bit_idx <= w[2:0];
		io_wr <= k == 0;
		io_rd <= k == 1;
		bit_set_instr <= k == 2;
		bit_clear_instr <= k == 3;
		@(posedge ref_clk);
		{io_wr, io_rd, bit_set_instr, bit_clear_instr} <= 4'h0;
		@(negedge ref_clk);
	endtask
	function automatic logic [7:0] pin_x(input logic [7:0] d, o, v);
		return d & o | ~d & v;
	endfunction
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#5000;
		n_mismatch++;
		complete_run;
	end
	initial begin
		v = $urandom(32'h6E50);
		repeat (5) @(posedge ref_clk);
		nrst <= 1'h1;
		for (int k = 0; k < 3; k++) begin
			d = $urandom;
			o = $urandom;
			v = $urandom;
			ext_val[8*k+:8] <= v;
			acc(6'(3*k+5), o, 0);
			chk(pad_pullup[8*k+:8], o);
			acc(6'(3*k+4), d, 0);
			chk(pad_oe[8*k+:8], d);
			chk(pad_out[8*k+:8], d & o);
			chk(pad_pullup[8*k+:8], ~d & o);
			acc(6'(3*k+3), 8'h00, 1);
			chk(io_rdata, pin_x(d, o, v));
			acc(6'(3*k+3), v, 0);
			acc(6'(3*k+5), 8'h00, 1);
			chk(io_rdata, o ^ v);
			acc(6'(3*k+4), 8'h05, 2);
			chk(pad_oe[8*k+:8], d | 8'h20);
			acc(6'(3*k+4), 8'h05, 3);
			chk(pad_oe[8*k+:8], d & 8'hDF);
			$display("port %0d done", k);
		end
		acc(6'h35, 8'hFF, 0);
		chk(8'(global_pullup_off), 8'h01);
		chk(8'(|pad_pullup), 8'h00);
		acc(6'h35, 8'h00, 1);
		chk(io_rdata, 8'h93);
		acc(6'h20, 8'h00, 1);
		chk(io_rdata, 8'h00);
		acc(6'h04, 8'h00, 0);
		@(posedge ref_clk);
		sleep_deep <= 1'h1;
		ext_int_en <= 24'h00000F;
		repeat (2) @(posedge ref_clk);
		acc(6'h03, 8'h00, 1);
		chk(io_rdata, ext_val[7:0] & 8'h0F);
		#2 nrst = 1'h0;
		#1 chk(8'(|{pad_oe, pad_pullup}), 8'h00);
		$display("control, sleep and reset done");
		complete_run;
	end
endmodule // tb_gdio_port
`default_nettype wire
